// ==== verilog/duhp_pkg.sv ====
// Package for the dual UART host port front end: constants and carriers
package duhp_pkg;
  // Register select offsets within a channel
  localparam logic [2:0] REG_DIV_LOW = 3'h0;
  localparam logic [2:0] REG_DIV_HIGH = 3'h1;
  localparam logic [2:0] REG_FIFO_CTL = 3'h2;
  localparam logic [2:0] REG_ALT_FUNC = 3'h3;
  localparam logic [2:0] REG_FEATURE = 3'h4;
  localparam logic [2:0] REG_LINE_STAT = 3'h5;
  localparam logic [2:0] REG_SCRATCH = 3'h7;
  // Field positions
  localparam int FIFO_EN_BIT = 0;
  localparam int BLOCK_MODE_BIT = 3;
  localparam int DUAL_WRITE_BIT = 0;
  localparam int MF_SEL_LO = 1;
  localparam int DIR_CTL_BIT = 3;
  localparam int TX_ROOM_BIT = 5;
  localparam int TX_EMPTY_BIT = 6;
  localparam logic [1:0] MF_RX_READY = 2'h2;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] DIV_ID_KEY = 8'h00;
  // Reset pulse length and the cycles it spans at 100 MHz
  localparam int RESET_MIN_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // Per-channel configuration
  typedef struct packed {
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] fifoCtl;
    logic [7:0] altFunc;
    logic [7:0] featCtl;
    logic [7:0] scratch;
  } duhp_chan_t;

  // Per-channel transfer status from the datapath
  typedef struct packed {
    logic rxCount;
    logic rxTrig;
    logic rxTimeout;
    logic txFull;
    logic txEmpty;
    logic txAboveTrig;
    logic shiftEmpty;
  } duhp_stat_t;

  // Per-channel pin outputs, all active low where named so
  typedef struct packed {
    logic rxReadyN;
    logic txReadyN;
    logic mfOutN;
    logic irq;
  } duhp_pins_t;

  // Module state apart from the write strobe path and oscillator divider
  typedef struct packed {
    duhp_chan_t [1:0] chan;
    logic [2:0][1:0] busSync;
    logic [1:0] rxBlockLow;
    duhp_pins_t [1:0] pins;
    logic [7:0] rdData;
    logic rdValid;
  } duhp_state_t;
endpackage

// ==== verilog/duhp_host_port.sv ====
// Host port, channel select, dual write, ID readback and ready/irq pins
//
// Behaviour
// RULE1: 8-bit data, 3 address lines, shared strobes
// RULE2: Bus cycles timed by select and strobes only
// RULE3: Host holds reset high beyond 40 ns
// RULE4: Zero divisor reads give identity and revision
// RULE5: Chip select high ignores bus; selector picks channel
// RULE6: Alternate bit 0 writes both channels
// RULE7: Host takes care with dual writes
// RULE8: Multifunction pin is receive ready when 10
// RULE9: FIFO control bit 3 selects block mode
// RULE10: Block mode receive ready: trigger low, empty high
// RULE11: Single mode receive ready low when data
// RULE12: Transmit ready low when FIFO or holding empty
// RULE13: Block mode transmit ready high only full
// RULE14: Line status bits 5, 6 show room, empty
// RULE15: No FIFO irq low while holding byte waits
// RULE16: FIFO transmit irq follows trigger or shifter
// RULE17: FIFO receive irq high above trigger
// RULE18: Oscillator feeds rate generators, not bus
// RULE19: Direction control off until feature bit 3
// RULE20: Read strobe drives data; write strobe latches
`timescale 1ns/1ps
module duhp_host_port #(
  parameter logic [7:0] ID_CODE = 8'h5a,  // Arbitrary identity value
  parameter logic [7:0] REV_CODE = 8'h03  // Arbitrary revision value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chipSelN,
  input wire logic channelSelector,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [2:0] addr,
  input wire logic [7:0] dataIn,
  input wire duhp_pkg::duhp_stat_t [1:0] chanStat,
  input wire logic oscillatorInput,
  output logic oscillatorOutput,
  output logic [7:0] dataOut,
  output logic dataOutEn,
  output logic receiveReadyAN,
  output logic receiveReadyBN,
  output logic transmitReadyAN,
  output logic transmitReadyBN,
  output logic multifunctionOutAN,
  output logic multifunctionOutBN,
  output logic channelAIrq,
  output logic channelBIrq,
  output logic [1:0] dirCtlActive
);

  duhp_pkg::duhp_state_t st_r;
  duhp_pkg::duhp_state_t st_nxt;
  logic oscBuf_r;
  logic csS;
  logic rdS;
  logic selS;

  ////////////////////////////////////////////////////////////////////////
  // Line status value of one channel
  function automatic logic [7:0] lineStat(input duhp_pkg::duhp_stat_t s);
    logic [7:0] v;
    v = 8'h00;
    v[duhp_pkg::TX_ROOM_BIT] = s.txEmpty;  // see RULE14
    v[duhp_pkg::TX_EMPTY_BIT] = s.txEmpty & s.shiftEmpty;  // see RULE14
    return v;
  endfunction

  // Register readback of one channel
  function automatic logic [7:0] readReg(
    input duhp_pkg::duhp_chan_t c,
    input duhp_pkg::duhp_stat_t s,
    input logic [2:0] a
  );
    logic idMode;
    logic [7:0] v;
    idMode = (c.divLow == duhp_pkg::DIV_ID_KEY) &&
             (c.divHigh == duhp_pkg::DIV_ID_KEY);
    v = 8'h00;
    unique case (a)
      duhp_pkg::REG_DIV_LOW: v = idMode ? REV_CODE : c.divLow;  // see RULE4
      duhp_pkg::REG_DIV_HIGH: v = idMode ? ID_CODE : c.divHigh;  // see RULE4
      duhp_pkg::REG_FIFO_CTL: v = c.fifoCtl;
      duhp_pkg::REG_ALT_FUNC: v = c.altFunc;
      duhp_pkg::REG_FEATURE: v = c.featCtl;
      duhp_pkg::REG_LINE_STAT: v = lineStat(s);
      duhp_pkg::REG_SCRATCH: v = c.scratch;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Oscillator halved by a toggle flop; rate generators live elsewhere, bus never uses it
  always_ff @(posedge oscillatorInput or posedge rst) begin  // see RULE18
    if (rst) begin
      oscBuf_r <= 1'b0;
    end else begin
      oscBuf_r <= ~oscBuf_r;
    end
  end
  assign oscillatorOutput = oscBuf_r;

  ////////////////////////////////////////////////////////////////////////
  // Synchronised bus pins; second stage only is read
  assign csS = ~st_r.busSync[0][1];
  assign selS = st_r.busSync[1][1];
  assign rdS = ~st_r.busSync[2][1] & csS;  // see RULE5

  // Write strobe synchroniser; third stage finds the end edge
  logic [2:0] wrSync_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrSync_r <= 3'h0;
    end else begin
      wrSync_r <= {wrSync_r[1:0], ~writeStrobeN & ~chipSelN};
    end
  end

  // Address and data sampled while the synchronised write strobe wrSync_r[1] is active
  logic [2:0] addrHold_r;
  logic [7:0] dataHold_r;
  logic selHold_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrHold_r <= 3'h0;
      dataHold_r <= 8'h00;
      selHold_r <= 1'b0;
    end else if (wrSync_r[1]) begin
      addrHold_r <= addr;
      dataHold_r <= dataIn;
      selHold_r <= channelSelector;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic wrEnd;
    logic dual;
    st_nxt = st_r;
    wrEnd = 1'b0;
    dual = 1'b0;
    st_nxt.busSync[0] = {st_r.busSync[0][0], chipSelN};
    st_nxt.busSync[1] = {st_r.busSync[1][0], channelSelector};
    st_nxt.busSync[2] = {st_r.busSync[2][0], readStrobeN};
    // Write lands when the synchronised strobe goes away
    wrEnd = wrSync_r[2] & ~wrSync_r[1];  // see RULE20
    for (int i = 0; i < 2; i++) begin
      // Channel A is selector 1, element 0; B is selector 0, element 1
      dual = st_r.chan[1 - int'(selHold_r)]
               .altFunc[duhp_pkg::DUAL_WRITE_BIT];  // see RULE6
      if (wrEnd && (dual || (i == (selHold_r ? 0 : 1)))) begin  // see RULE5
        unique case (addrHold_r)
          duhp_pkg::REG_DIV_LOW: st_nxt.chan[i].divLow = dataHold_r;
          duhp_pkg::REG_DIV_HIGH: st_nxt.chan[i].divHigh = dataHold_r;
          duhp_pkg::REG_FIFO_CTL: st_nxt.chan[i].fifoCtl = dataHold_r;
          duhp_pkg::REG_ALT_FUNC: st_nxt.chan[i].altFunc = dataHold_r;
          duhp_pkg::REG_FEATURE: st_nxt.chan[i].featCtl = dataHold_r;
          duhp_pkg::REG_SCRATCH: st_nxt.chan[i].scratch = dataHold_r;
          default: ;
        endcase
      end
    end
    // Read data path
    st_nxt.rdValid = rdS;  // see RULE20
    st_nxt.rdData = readReg(st_r.chan[selS ? 0 : 1],
                            chanStat[selS ? 0 : 1], addr);  // see RULE1
    // Pin logic per channel
    for (int i = 0; i < 2; i++) begin
      logic fifoOn;
      logic blk;
      logic dirOn;
      logic txIrqHigh;
      txIrqHigh = 1'b0;
      fifoOn = st_r.chan[i].fifoCtl[duhp_pkg::FIFO_EN_BIT];
      blk = fifoOn & st_r.chan[i].fifoCtl[duhp_pkg::BLOCK_MODE_BIT];
      dirOn = st_r.chan[i].featCtl[duhp_pkg::DIR_CTL_BIT];  // see RULE19
      // Block mode receive flag: set at trigger or timeout, clear on empty
      if (chanStat[i].rxTrig || chanStat[i].rxTimeout) begin
        st_nxt.rxBlockLow[i] = 1'b1;  // see RULE10
      end else if (!chanStat[i].rxCount) begin
        st_nxt.rxBlockLow[i] = 1'b0;  // see RULE10
      end
      if (blk) begin  // see RULE9
        st_nxt.pins[i].rxReadyN = ~st_nxt.rxBlockLow[i];  // see RULE10
        st_nxt.pins[i].txReadyN = chanStat[i].txFull;  // see RULE13
      end else begin
        st_nxt.pins[i].rxReadyN = ~chanStat[i].rxCount;  // see RULE11
        st_nxt.pins[i].txReadyN = ~chanStat[i].txEmpty;  // see RULE12
      end
      // Transmit interrupt high as room appears, or shifter done in dir mode
      if (fifoOn) begin
        txIrqHigh = dirOn ? (chanStat[i].txEmpty & chanStat[i].shiftEmpty)
                          : ~chanStat[i].txAboveTrig;  // see RULE16
        st_nxt.pins[i].irq = txIrqHigh | chanStat[i].rxTrig;  // see RULE17
      end else begin
        st_nxt.pins[i].irq = dirOn
          ? (chanStat[i].txEmpty & chanStat[i].shiftEmpty)
          : chanStat[i].txEmpty;  // see RULE15
      end
      // Multifunction pin mirrors receive ready when so selected
      if (st_r.chan[i].altFunc[duhp_pkg::MF_SEL_LO +: 2] ==
          duhp_pkg::MF_RX_READY) begin
        st_nxt.pins[i].mfOutN = st_nxt.pins[i].rxReadyN;  // see RULE8
      end else begin
        st_nxt.pins[i].mfOutN = 1'b1;
      end
    end
  end

  // State register; reset takes constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin  // see RULE3
      st_r <= '0;
      st_r.busSync <= '1;
      st_r.pins <= {2{4'he}};  // Ready pins high, irq low
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign dataOut = st_r.rdData;
  assign dataOutEn = st_r.rdValid;
  assign receiveReadyAN = st_r.pins[0].rxReadyN;
  assign receiveReadyBN = st_r.pins[1].rxReadyN;
  assign transmitReadyAN = st_r.pins[0].txReadyN;
  assign transmitReadyBN = st_r.pins[1].txReadyN;
  assign multifunctionOutAN = st_r.pins[0].mfOutN;
  assign multifunctionOutBN = st_r.pins[1].mfOutN;
  assign channelAIrq = st_r.pins[0].irq;
  assign channelBIrq = st_r.pins[1].irq;
  assign dirCtlActive = {st_r.chan[1].featCtl[duhp_pkg::DIR_CTL_BIT],
                         st_r.chan[0].featCtl[duhp_pkg::DIR_CTL_BIT]};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_id_readback: assert property (@(posedge clk) disable iff (rst)  // see RULE4
    (rdS && addr == duhp_pkg::REG_DIV_HIGH &&
     st_r.chan[selS ? 0 : 1].divLow == 8'h00 &&
     st_r.chan[selS ? 0 : 1].divHigh == 8'h00) |=> (dataOut == ID_CODE))
    else $error("identity code not returned");
  chk_deselect_quiet: assert property (@(posedge clk) disable iff (rst)  // see RULE5
    (!csS) |=> !dataOutEn)
    else $error("data driven while deselected");
  chk_block_tx_ready: assert property (@(posedge clk) disable iff (rst)  // see RULE13
    (st_r.chan[0].fifoCtl[0] && st_r.chan[0].fifoCtl[3])
      |=> (transmitReadyAN == $past(chanStat[0].txFull)))
    else $error("block transmit ready wrong");
  chk_single_rx_ready: assert property (@(posedge clk) disable iff (rst)  // see RULE11
    (!st_r.chan[1].fifoCtl[3]) |=> (receiveReadyBN == !$past(chanStat[1].rxCount)))
    else $error("single receive ready wrong");
  chk_block_rx_hold: assert property (@(posedge clk) disable iff (rst)  // see RULE10
    (chanStat[0].rxTrig && st_r.chan[0].fifoCtl[0] && st_r.chan[0].fifoCtl[3])
      |=> !receiveReadyAN)
    else $error("block receive ready not low at trigger");
  chk_mf_follow: assert property (@(posedge clk) disable iff (rst)  // see RULE8
    (st_r.chan[0].altFunc[2:1] == 2'h2) |=> (multifunctionOutAN == receiveReadyAN))
    else $error("multifunction pin not receive ready");
  chk_nofifo_irq: assert property (@(posedge clk) disable iff (rst)  // see RULE15
    (!st_r.chan[0].fifoCtl[0] && !st_r.chan[0].featCtl[3])
      |=> (channelAIrq == $past(chanStat[0].txEmpty)))
    else $error("transmit irq wrong without FIFO");
  chk_dual_write: assert property (@(posedge clk) disable iff (rst)  // see RULE6
    (wrSync_r[2] && !wrSync_r[1] && addrHold_r == duhp_pkg::REG_SCRATCH &&
     st_r.chan[0].altFunc[0] && st_r.chan[1].altFunc[0])
      |=> (st_r.chan[0].scratch == st_r.chan[1].scratch))
    else $error("dual write missed a channel");
endmodule

// ==== test/duhp_host_model.sv ====
// Host processor model driving the asynchronous parallel bus
`timescale 1ns/1ps
module duhp_host_model (
  input wire logic clk,
  input wire logic dataOutEn,
  output logic chipSelN,
  output logic channelSelector,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic [2:0] addr,
  output logic [7:0] dataIn,
  output logic hung
);
  // Bus idle at time zero
  initial begin
    chipSelN = 1'b1;
    channelSelector = 1'b1;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    addr = 3'h0;
    dataIn = 8'h00;
    hung = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle; strobe held four cycles, data released afterwards
  task automatic wr(input logic cs, input logic ch, input logic [2:0] a,
                    input logic [7:0] d);
    @(negedge clk);
    chipSelN = cs;
    channelSelector = ch;
    addr = a;
    dataIn = d;
    writeStrobeN = 1'b0;
    repeat (4) @(negedge clk);
    writeStrobeN = 1'b1;
    repeat (3) @(negedge clk);
    chipSelN = 1'b1;
    dataIn = ~d; // Released bus shows no stale value
    repeat (6) @(negedge clk);
  endtask

  // Read cycle; strobe held until the answer is sampled
  task automatic rd(input logic ch, input logic [2:0] a);
    int n;
    @(negedge clk);
    chipSelN = 1'b0;
    channelSelector = ch;
    addr = a;
    readStrobeN = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dataOutEn !== 1'b1 && n < 20);
    if (n >= 20) hung = 1'b1;
    @(negedge clk);
    readStrobeN = 1'b1;
    @(negedge clk);
    chipSelN = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ==== test/tb_dual_uart_host_port_flags.sv ====
// Self-checking testbench for the dual UART host port front end
`timescale 1ns/1ps
module tb_dual_uart_host_port_flags;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic osc = 1'b0;
  logic chipSelN, channelSelector, readStrobeN, writeStrobeN, hung;
  logic [2:0] addr;
  logic [7:0] dataIn, dataOut, sa, sb;
  logic dataOutEn, rxAN, rxBN, txAN, txBN, mfAN, mfBN, irqA, irqB;
  logic prevEn = 1'b0;
  logic [1:0] dirCtl;
  duhp_pkg::duhp_stat_t [1:0] chanStat = '0;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk = ~clk;
  always #7 osc = ~osc;

  duhp_host_port #(.ID_CODE(8'h3c), .REV_CODE(8'h07)) dut_u ( // Arbitrary
    .clk(clk), .rst(rst), .chipSelN(chipSelN),
    .channelSelector(channelSelector), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .addr(addr), .dataIn(dataIn),
    .chanStat(chanStat), .oscillatorInput(osc), .oscillatorOutput(),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .receiveReadyAN(rxAN),
    .receiveReadyBN(rxBN), .transmitReadyAN(txAN), .transmitReadyBN(txBN),
    .multifunctionOutAN(mfAN), .multifunctionOutBN(mfBN),
    .channelAIrq(irqA), .channelBIrq(irqB), .dirCtlActive(dirCtl));

  duhp_host_model host_u (
    .clk(clk), .dataOutEn(dataOutEn), .chipSelN(chipSelN),
    .channelSelector(channelSelector), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .addr(addr), .dataIn(dataIn), .hung(hung));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and read helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rd(input logic ch, input logic [2:0] a,
                    input logic [7:0] e, input logic [7:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    host_u.rd(ch, a);
  endtask

  // Status change on channel A, random on B, then pin compare
  task automatic pin(input logic [6:0] s, input logic [3:0] e,
                     input logic [3:0] m);
    @(negedge clk);
    chanStat[0] = s;
    chanStat[1] = 7'($urandom);
    repeat (3) @(negedge clk);
    check({4'h0, {rxAN, txAN, mfAN, irqA} & m}, {4'h0, e});
  endtask

  // Read monitor: oldest note compared when read data appears
  always @(posedge clk) begin
    #1;
    if (dataOutEn === 1'b1 && prevEn !== 1'b1) begin
      if (expQ.size() == 0) check(8'h01, 8'h00);
      else check(dataOut & mskQ.pop_front(), expQ.pop_front());
    end
    prevEn = dataOutEn;
    if (hung === 1'b1) begin
      mismatches++;
      end_sim();
    end
  end

  // Overall bound on the run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(58));
    sa = 8'($urandom);
    sb = ~sa;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check({rxAN, txAN, mfAN, irqA, rxBN, txBN, mfBN, irqB}, 8'hee);
    check({6'h0, dirCtl}, 8'h00);
    repeat (3) @(negedge clk);
    rd(1'b1, duhp_pkg::REG_DIV_HIGH, 8'h3c, 8'hff);
    rd(1'b0, duhp_pkg::REG_DIV_LOW, 8'h07, 8'hff);
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_DIV_LOW, 8'h18);
    rd(1'b1, duhp_pkg::REG_DIV_LOW, 8'h18, 8'hff);
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_SCRATCH, sa);
    host_u.wr(1'b0, 1'b0, duhp_pkg::REG_SCRATCH, sb);
    host_u.wr(1'b1, 1'b1, duhp_pkg::REG_SCRATCH, 8'h00);
    rd(1'b1, duhp_pkg::REG_SCRATCH, sa, 8'hff);
    rd(1'b0, duhp_pkg::REG_SCRATCH, sb, 8'hff);
    rd(1'b1, 3'h6, 8'h00, 8'hff);
    // Dual write while both channels are idle
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_ALT_FUNC, 8'h05);
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_SCRATCH, sa);
    rd(1'b0, duhp_pkg::REG_SCRATCH, sa, 8'hff);
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_ALT_FUNC, 8'h04);
    rd(1'b0, duhp_pkg::REG_ALT_FUNC, 8'h04, 8'hff);
    // Single-character FIFO mode
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_FIFO_CTL, 8'h01);
    pin(7'h40, 4'h4, 4'he);
    pin(7'h04, 4'ha, 4'he);
    pin(7'h62, 4'h5, 4'hf);
    pin(7'h02, 4'he, 4'hf);
    // Block mode with receive hysteresis
    pin(7'h00, 4'he, 4'he);
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_FIFO_CTL, 8'h09);
    pin(7'h40, 4'ha, 4'he);
    pin(7'h60, 4'h0, 4'he);
    pin(7'h40, 4'h0, 4'he);
    pin(7'h08, 4'he, 4'he);
    // No FIFO, then half-duplex direction mode
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_FIFO_CTL, 8'h00);
    pin(7'h00, 4'h4, 4'h5);
    pin(7'h04, 4'h1, 4'h5);
    host_u.wr(1'b0, 1'b1, duhp_pkg::REG_FEATURE, 8'h08);
    check({6'h0, dirCtl}, 8'h01);
    pin(7'h04, 4'h0, 4'h1);
    pin(7'h05, 4'h1, 4'h1);
    rd(1'b1, duhp_pkg::REG_LINE_STAT, 8'h60, 8'h60);
    repeat (5) @(negedge clk);
    end_sim();
  end
endmodule
